// File: src/nvm_device.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"

module nvm_device #(
  parameter int PAGE_BYTES = 32,
  parameter int PAGES      = 4
) (
  input  wire logic   clock,
  input  wire logic   sys_rst,
  nvm_link_if.device  link,
  input  wire logic   readLock,
  input  wire logic   writeLock,
  input  wire logic   eepromPreserveFuse,
  output logic        busy
);
  localparam int PB = $clog2(PAGE_BYTES);
  localparam int EW = $clog2(PAGE_BYTES * PAGES);
  localparam int EE_BYTES = PAGE_BYTES * PAGES;
  localparam logic [15:0] OP_LAST = 16'(`OP_CYCLES - 1);

  logic [7:0]            ee [EE_BYTES];
  logic [7:0]            pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] tag;
  logic [6:0]            cmdReg;
  logic [15:0]           addrReg;
  logic [7:0]            dataByteZero;
  logic [3:0]            unlockCount;
  logic                  resetSeen;
  logic                  accessEnabled;
  nvm_pkg::state_t       state;
  logic [6:0]            opCmd;
  logic [EW-1:0]         opAddr;
  logic [15:0]           timer;
  logic                  readyReg;
  logic [7:0]            rdataReg;
  nvm_pkg::cmd_info_t    info;
  logic                  take;
  logic                  regWr;
  logic                  memAcc;
  logic                  locked;
  logic                  acceptNow;
  logic                  execGo;
  logic                  memWrGo;
  logic                  dataLoadGo;
  logic                  startOp;
  logic                  eeRegion;
  logic                  loadBuf;
  logic                  phaseEnd;
  logic                  writeEnd;
  logic [PB-1:0]         loadIdx;
  logic [7:0]            loadData;

  // Request decode; a pulse of ready closes each link access
  assign info     = nvm_pkg::decode(cmdReg, accessEnabled);
  assign take     = link.sel && !readyReg;
  assign regWr    = take && link.space && link.wr;
  assign memAcc   = take && !link.space;
  assign eeRegion = link.addr[11:10] == `EE_MAP_BASE;
  assign busy     = state != nvm_pkg::ST_IDLE;
  assign locked   = accessEnabled && readLock && writeLock
                    && cmdReg != `CMD_CHIP_ERASE && cmdReg != `CMD_FLASH_CRC;
  // A memory read waits out a running operation
  assign acceptNow = take && !(memAcc && !link.wr && busy);

  // Launch conditions per trigger kind
  assign execGo = regWr && link.addr[3:0] == `REG_CONTROL_A && link.wdata[`EXEC_BIT]
                  && info.trig == nvm_pkg::TRIG_EXEC && !busy && !locked
                  && (!info.prot || accessEnabled || unlockCount != 4'h0);
  assign memWrGo = memAcc && link.wr && accessEnabled && !busy && !locked
                   && info.trig == nvm_pkg::TRIG_WRITE;
  assign dataLoadGo = regWr && link.addr[3:0] == `REG_DATA_BYTE && !accessEnabled && !busy
                      && info.trig == nvm_pkg::TRIG_WRITE && unlockCount != 4'h0;
  assign startOp = (execGo || memWrGo) && info.busy;
  assign loadBuf = dataLoadGo || (memWrGo && cmdReg == `CMD_LD_EE_BUF && eeRegion);
  // Only the low address bits choose the buffer slot
  assign loadIdx  = dataLoadGo ? addrReg[PB-1:0] : link.addr[PB-1:0];
  assign loadData = link.wdata;
  assign phaseEnd = busy && timer == 16'h0;
  assign writeEnd = phaseEnd && (state == nvm_pkg::ST_RUN2 || opCmd == `CMD_WR_EE_PG);

  assign link.ready = readyReg;
  assign link.rdata = rdataReg;
  assign link.busy  = busy;
  // Access drops while chip erase or flash CRC owns the array
  assign link.accessEnabled = accessEnabled
      && !(busy && (opCmd == `CMD_CHIP_ERASE || opCmd == `CMD_FLASH_CRC));

  // Software-visible registers and the unlock windows
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmdReg <= `CMD_NOP;
      addrReg <= 16'h0000;
      unlockCount <= 4'h0;
      resetSeen <= 1'b0;
      accessEnabled <= 1'b0;
    end else begin
      if (regWr && link.addr[3:0] == `REG_CMD) cmdReg <= link.wdata[6:0];
      if (regWr && link.addr[3:0] == `REG_ADDR_LO) addrReg[7:0] <= link.wdata;
      if (regWr && link.addr[3:0] == `REG_ADDR_HI) addrReg[15:8] <= link.wdata;
      if (regWr && link.addr[3:0] == `REG_UNLOCK && link.wdata == `UNLOCK_KEY) begin
        unlockCount <= `UNLOCK_WINDOW;
      end else if (unlockCount != 4'h0) begin
        unlockCount <= unlockCount - 4'h1;
      end
      // Reset key first, then the memory key, enables access
      if (regWr && link.addr[3:0] == `REG_DBG_RESET) begin
        resetSeen <= link.wdata == `DBG_RESET_KEY;
        if (link.wdata != `DBG_RESET_KEY) accessEnabled <= 1'b0;
      end
      if (regWr && link.addr[3:0] == `REG_NVM_KEY && resetSeen
          && link.wdata == `NVM_KEY_BYTE) begin
        accessEnabled <= 1'b1;
      end
    end
  end

  // Data register: bus write or execute-triggered read result
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dataByteZero <= 8'h00;
    end else if (execGo && cmdReg == `CMD_RD_EE) begin
      dataByteZero <= ee[addrReg[EW-1:0]];
    end else if (regWr && link.addr[3:0] == `REG_DATA_BYTE) begin
      dataByteZero <= link.wdata;
    end
  end

  // Operation sequencer; EEPROM page erase-write runs two timed phases
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= nvm_pkg::ST_IDLE;
      opCmd <= `CMD_NOP;
      opAddr <= '0;
      timer <= 16'h0;
    end else begin
      case (state)
        nvm_pkg::ST_IDLE: begin
          if (startOp) begin
            state <= nvm_pkg::ST_RUN;
            opCmd <= cmdReg;
            opAddr <= accessEnabled ? link.addr[EW-1:0] : addrReg[EW-1:0];
            timer <= OP_LAST;
          end
        end
        nvm_pkg::ST_RUN: begin
          if (timer != 16'h0) begin
            timer <= timer - 16'h1;
          end else if (opCmd == `CMD_EW_EE_PG) begin
            state <= nvm_pkg::ST_RUN2;
            timer <= OP_LAST;
          end else begin
            state <= nvm_pkg::ST_IDLE;
          end
        end
        nvm_pkg::ST_RUN2: begin
          if (timer != 16'h0) timer <= timer - 16'h1;
          else state <= nvm_pkg::ST_IDLE;
        end
        default: state <= nvm_pkg::ST_IDLE;
      endcase
    end
  end

  // Page buffer and tags; loads happen only while idle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tag <= '0;
      for (int j = 0; j < PAGE_BYTES; j++) pbuf[j] <= `ERASED_BYTE;
    end else if (loadBuf) begin
      pbuf[loadIdx] <= loadData;
      tag[loadIdx] <= 1'b1;
    end else if (writeEnd || (phaseEnd && (opCmd == `CMD_ER_EE_BUF
                 || opCmd == `CMD_CHIP_ERASE))) begin
      tag <= '0;
      for (int j = 0; j < PAGE_BYTES; j++) pbuf[j] <= `ERASED_BYTE;
    end
  end

  // Array update at the end of each timed phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < EE_BYTES; i++) ee[i] <= `ERASED_BYTE;
    end else if (phaseEnd && state == nvm_pkg::ST_RUN) begin
      case (opCmd)
        `CMD_ER_EE_PG, `CMD_EW_EE_PG: begin
          for (int j = 0; j < PAGE_BYTES; j++) begin
            if (tag[j]) ee[{opAddr[EW-1:PB], PB'(j)}] <= `ERASED_BYTE;
          end
        end
        `CMD_WR_EE_PG: begin
          for (int j = 0; j < PAGE_BYTES; j++) begin
            if (tag[j]) ee[{opAddr[EW-1:PB], PB'(j)}] <= pbuf[j];
          end
        end
        `CMD_ER_EE: begin
          for (int i = 0; i < EE_BYTES; i++) begin
            if (tag[i % PAGE_BYTES]) ee[i] <= `ERASED_BYTE;
          end
        end
        `CMD_CHIP_ERASE: begin
          if (!eepromPreserveFuse) begin
            for (int i = 0; i < EE_BYTES; i++) ee[i] <= `ERASED_BYTE;
          end
        end
        default: ;
      endcase
    end else if (phaseEnd && state == nvm_pkg::ST_RUN2) begin
      for (int j = 0; j < PAGE_BYTES; j++) begin
        if (tag[j]) ee[{opAddr[EW-1:PB], PB'(j)}] <= pbuf[j];
      end
    end
  end

  // Link answer; unmapped memory reads as erased
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readyReg <= 1'b0;
      rdataReg <= 8'h00;
    end else begin
      readyReg <= acceptNow;
      if (acceptNow && !link.wr) begin
        if (link.space) begin
          case (link.addr[3:0])
            `REG_CMD:     rdataReg <= {1'b0, cmdReg};
            `REG_ADDR_LO: rdataReg <= addrReg[7:0];
            `REG_ADDR_HI: rdataReg <= addrReg[15:8];
            `REG_DATA_BYTE: rdataReg <= dataByteZero;
            `REG_CONTROL_A: rdataReg <= 8'h00;
            `REG_STATUS:  rdataReg <= {busy, 5'h00, link.accessEnabled, 1'b0};
            default:      rdataReg <= 8'h00;
          endcase
        end else if (accessEnabled && !locked && eeRegion
                     && (cmdReg == `CMD_RD_EE || cmdReg == `CMD_RD_NVM)) begin
          rdataReg <= ee[link.addr[EW-1:0]];
        end else begin
          rdataReg <= `ERASED_BYTE;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: src/nvm_map.svh
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// Device register indices on the link (register space)
`define REG_CMD        4'h0
`define REG_ADDR_LO    4'h1
`define REG_ADDR_HI    4'h2
`define REG_DATA_BYTE  4'h3
`define REG_CONTROL_A  4'h4
`define REG_STATUS     4'h5
`define REG_UNLOCK     4'h6
`define REG_DBG_RESET  4'h7
`define REG_NVM_KEY    4'h8
`define EXEC_BIT       0
`define STATUS_BUSY    7
`define STATUS_ACCESS  1
`define UNLOCK_KEY     8'hD8
`define UNLOCK_WINDOW  4'h4
`define DBG_RESET_KEY  8'h59
`define NVM_KEY_BYTE   8'hA5
`define ERASED_BYTE    8'hFF

// Mapped memory window for the EEPROM in link memory space
`define EE_MAP_BASE    2'h3

// Command codes
`define CMD_NOP        7'h00
`define CMD_RD_USERSIG 7'h01
`define CMD_RD_CALIB   7'h02
`define CMD_RD_EE      7'h06
`define CMD_RD_FUSE    7'h07
`define CMD_WR_LOCK    7'h08
`define CMD_ER_USERSIG 7'h18
`define CMD_WR_USERSIG 7'h1A
`define CMD_ER_APP     7'h20
`define CMD_ER_APP_PG  7'h22
`define CMD_LD_FL_BUF  7'h23
`define CMD_WR_APP_PG  7'h24
`define CMD_EW_APP_PG  7'h25
`define CMD_ER_FL_BUF  7'h26
`define CMD_ER_BOOT_PG 7'h2A
`define CMD_ER_FL_PG   7'h2B
`define CMD_WR_BOOT_PG 7'h2C
`define CMD_EW_BOOT_PG 7'h2D
`define CMD_WR_FL_PG   7'h2E
`define CMD_EW_FL_PG   7'h2F
`define CMD_ER_EE      7'h30
`define CMD_ER_EE_PG   7'h32
`define CMD_LD_EE_BUF  7'h33
`define CMD_WR_EE_PG   7'h34
`define CMD_EW_EE_PG   7'h35
`define CMD_ER_EE_BUF  7'h36
`define CMD_APP_CRC    7'h38
`define CMD_BOOT_CRC   7'h39
`define CMD_CHIP_ERASE 7'h40
`define CMD_RD_NVM     7'h43
`define CMD_WR_FUSE    7'h4C
`define CMD_ER_BOOT    7'h68
`define CMD_FLASH_CRC  7'h78

// Operation timing
`define CLK_PERIOD_NS  100
`define OP_TIME_NS     2000
`define OP_CYCLES      ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Host register byte offsets on APB
`define HOST_LNK_ADDR  8'h00
`define HOST_LNK_DATA  8'h04
`define HOST_LNK_CTRL  8'h08
`define HOST_STATUS    8'h0C

`endif

// File: src/nvm_pkg.sv
`default_nettype none
`include "nvm_map.svh"

package nvm_pkg;

  typedef enum logic [1:0] {
    TRIG_NONE  = 2'h0,
    TRIG_EXEC  = 2'h1,
    TRIG_READ  = 2'h2,
    TRIG_WRITE = 2'h3
  } trig_t;

  typedef struct packed {
    trig_t trig;
    logic  prot;
    logic  busy;
  } cmd_info_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_RUN2 = 2'b11
  } state_t;

  // Trigger kind, change protection and busy per command and mode
  function automatic cmd_info_t decode(input logic [6:0] cmd, input logic ext);
    cmd_info_t i;
    i = '{TRIG_NONE, 1'b0, 1'b0};
    if (ext) begin
      case (cmd)
        `CMD_CHIP_ERASE, `CMD_ER_FL_BUF, `CMD_FLASH_CRC, `CMD_APP_CRC, `CMD_BOOT_CRC,
        `CMD_WR_LOCK, `CMD_ER_EE_BUF, `CMD_ER_EE: i = '{TRIG_EXEC, 1'b1, 1'b1};
        `CMD_RD_NVM, `CMD_RD_USERSIG, `CMD_RD_CALIB, `CMD_RD_FUSE,
        `CMD_RD_EE: i = '{TRIG_READ, 1'b0, 1'b0};
        `CMD_LD_FL_BUF, `CMD_LD_EE_BUF: i = '{TRIG_WRITE, 1'b0, 1'b0};
        `CMD_ER_FL_PG, `CMD_WR_FL_PG, `CMD_EW_FL_PG, `CMD_ER_APP, `CMD_ER_APP_PG,
        `CMD_WR_APP_PG, `CMD_EW_APP_PG, `CMD_ER_BOOT, `CMD_ER_BOOT_PG,
        `CMD_WR_BOOT_PG, `CMD_EW_BOOT_PG, `CMD_ER_USERSIG, `CMD_WR_USERSIG,
        `CMD_WR_FUSE, `CMD_ER_EE_PG, `CMD_WR_EE_PG,
        `CMD_EW_EE_PG: i = '{TRIG_WRITE, 1'b0, 1'b1};
        default: i = '{TRIG_NONE, 1'b0, 1'b0};
      endcase
    end else begin
      case (cmd)
        `CMD_LD_EE_BUF: i = '{TRIG_WRITE, 1'b1, 1'b0};
        `CMD_ER_EE_BUF, `CMD_ER_EE_PG, `CMD_WR_EE_PG, `CMD_EW_EE_PG,
        `CMD_ER_EE: i = '{TRIG_EXEC, 1'b1, 1'b1};
        `CMD_RD_EE: i = '{TRIG_EXEC, 1'b1, 1'b0};
        default: i = '{TRIG_NONE, 1'b0, 1'b0};
      endcase
    end
    return i;
  endfunction

endpackage

`default_nettype wire

// File: src/nvm_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface nvm_link_if (
  input wire logic clock
);
  logic        sel;
  logic        wr;
  logic        space;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        ready;
  logic        busy;
  logic        accessEnabled;

  modport device (
    input  sel, wr, space, addr, wdata,
    output rdata, ready, busy, accessEnabled
  );

  modport host (
    output sel, wr, space, addr, wdata,
    input  rdata, ready, busy, accessEnabled
  );
endinterface

`default_nettype wire

// File: src/nvm_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"

// APB-driven controller that issues link accesses
module nvm_host (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  nvm_link_if.host         link
);
  logic [12:0] lnkAddr;
  logic [7:0]  lnkData;
  logic [7:0]  lastRdata;
  logic        pending;
  logic        setup;
  logic        wrAccess;
  logic        mapped;

  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite;
  assign mapped   = paddr == `HOST_LNK_ADDR || paddr == `HOST_LNK_DATA
                    || paddr == `HOST_LNK_CTRL || paddr == `HOST_STATUS;
  // Zero wait states; read data was latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Staged link request fields
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lnkAddr <= 13'h0000;
      lnkData <= 8'h00;
    end else if (wrAccess && !pending) begin
      if (paddr == `HOST_LNK_ADDR) lnkAddr <= pwdata[12:0];
      if (paddr == `HOST_LNK_DATA) lnkData <= pwdata[7:0];
    end
  end

  // Link request held until the device answers; start ignored while pending
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pending <= 1'b0;
      link.sel <= 1'b0;
      link.wr <= 1'b0;
      link.space <= 1'b0;
      link.addr <= 12'h000;
      link.wdata <= 8'h00;
      lastRdata <= 8'h00;
    end else if (pending) begin
      if (link.ready) begin
        pending <= 1'b0;
        link.sel <= 1'b0;
        if (!link.wr) lastRdata <= link.rdata;
      end
    end else if (wrAccess && paddr == `HOST_LNK_CTRL && pwdata[0]) begin
      pending <= 1'b1;
      link.sel <= 1'b1;
      link.wr <= pwdata[1];
      link.space <= lnkAddr[12];
      link.addr <= lnkAddr[11:0];
      link.wdata <= lnkData;
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `HOST_LNK_ADDR: prdata <= {19'h0, lnkAddr};
        `HOST_LNK_DATA: prdata <= {24'h0, lnkData};
        `HOST_STATUS:   prdata <= {16'h0, lastRdata, 5'h0, link.accessEnabled,
                                   link.busy, pending};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: verif/nvm_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"

module nvm_link_properties (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        sel,
  input wire logic        wr,
  input wire logic        space,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        ready,
  input wire logic        busy,
  input wire logic        accessEnabled
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [7:0] busyRun;

  // Busy run length, so fixed operation times can be judged
  always_ff @(posedge clock) begin
    if (sys_rst)
      busyRun <= 8'h00;
    else
      busyRun <= busy ? busyRun + 8'h01 : 8'h00;
  end

  property p_ready_pulse; ready |=> !ready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  property p_ready_sel; ready |-> sel ##1 !sel; endproperty
  a_ready_sel: assert property (p_ready_sel)
    else $error("ready without a request or request not dropped");
  property p_sel_hold;
    sel && !ready |=> sel && $stable({wr, space, addr, wdata});
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("request changed before its answer");
  property p_reg_answer; $rose(sel) && space |=> ready; endproperty
  a_reg_answer: assert property (p_reg_answer)
    else $error("register access not answered next cycle");
  // A memory read answered now was taken while the memory was free
  property p_read_blocked; ready && !space && !wr |-> !$past(busy); endproperty
  a_read_blocked: assert property (p_read_blocked)
    else $error("memory read answered while busy");
  property p_busy_len;
    $fell(busy) |-> busyRun == 8'h14 || busyRun == 8'h28;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy run has wrong length");
  property p_busy_bound; busy |-> busyRun < 8'h28; endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy run too long");
  // Enabling only by the key, or by return after a chip erase or flash CRC
  property p_access_rise;
    $rose(accessEnabled) |-> $past(wdata) == `NVM_KEY_BYTE || $past(busy) || $past(busy, 2);
  endproperty
  a_access_rise: assert property (p_access_rise)
    else $error("access enabled without the key");
  property p_rdata_hold; $changed(rdata) |-> ready && !wr; endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read answer");

  c_busy: cover property ($rose(busy));
  c_long: cover property ($fell(busy) && busyRun == 8'h28);
  c_access: cover property ($rose(accessEnabled));
  c_memread: cover property (ready && !space && !wr);
endmodule

`default_nettype wire

// File: verif/test_nvm_eeprom_and_external_program_cmds.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_map.svh"

module test_nvm_eeprom_and_external_program_cmds;
  logic        clock;
  logic        sys_rst;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        readLock;
  logic        writeLock;
  logic        eepromPreserveFuse;
  logic        busy;
  logic [31:0] rd;
  logic        err;
  int          errorCnt;
  int          checks;

  nvm_link_if nvm_link_if_inst (.clock(clock));

  nvm_host nvm_host_inst (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(nvm_link_if_inst));

  nvm_device nvm_device_inst (.clock(clock), .sys_rst(sys_rst), .link(nvm_link_if_inst),
    .readLock(readLock), .writeLock(writeLock), .eepromPreserveFuse(eepromPreserveFuse),
    .busy(busy));

  nvm_link_properties nvm_link_properties_inst (.clock(clock), .sys_rst(sys_rst),
    .sel(nvm_link_if_inst.sel), .wr(nvm_link_if_inst.wr), .space(nvm_link_if_inst.space),
    .addr(nvm_link_if_inst.addr), .wdata(nvm_link_if_inst.wdata),
    .rdata(nvm_link_if_inst.rdata), .ready(nvm_link_if_inst.ready),
    .busy(nvm_link_if_inst.busy), .accessEnabled(nvm_link_if_inst.accessEnabled));

  // Free-running clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic completeRun;
    $display("checks=%0d mismatches=%0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      errorCnt++;
      completeRun();
    end
  endtask

  // One APB transfer; result in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hang(n, 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One link access; bit 12 of a selects register space
  task automatic link(input logic [12:0] a, input logic [7:0] d, input logic w);
    int n;
    n = 0;
    apb(1'b1, `HOST_LNK_ADDR, {19'h00000, a});
    apb(1'b1, `HOST_LNK_DATA, {24'h000000, d});
    apb(1'b1, `HOST_LNK_CTRL, {30'h00000000, w, 1'b1});
    do begin
      apb(1'b0, `HOST_STATUS, 32'h00000000);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    hang(n, 200);
    rd = {24'h000000, rd[15:8]};
  endtask

  task automatic regw(input logic [3:0] i, input logic [7:0] d);
    link({9'h100, i}, d, 1'b1);
  endtask

  // EEPROM window lies at addr[11:10] = 3
  task automatic eew(input logic [6:0] i, input logic [7:0] d);
    link({3'h3, 3'h0, i}, d, 1'b1);
  endtask

  task automatic eer(input logic [6:0] i, input logic [7:0] e);
    link({3'h3, 3'h0, i}, 8'h00, 1'b0);
    check(rd, {24'h000000, e});
  endtask

  // Checks busy right after the trigger, then waits for idle and access
  task automatic idle(input logic b);
    int n;
    n = 0;
    apb(1'b0, `HOST_STATUS, 32'h00000000);
    check({31'h00000000, rd[1]}, {31'h00000000, b});
    check({31'h00000000, busy}, {31'h00000000, b});
    while ((rd[1] !== 1'b0 || rd[2] !== 1'b1) && n < 100) begin
      apb(1'b0, `HOST_STATUS, 32'h00000000);
      n++;
    end
    hang(n, 100);
  endtask

  task automatic cmd(input logic [6:0] c, input logic ex, input logic [12:0] a, input logic b);
    regw(`REG_CMD, {1'b0, c});
    if (ex)
      regw(`REG_CONTROL_A, 8'h01);
    else
      link(a, 8'h00, 1'b1);
    idle(b);
  endtask

  task automatic t_reset;
    apb(1'b0, `HOST_STATUS, 32'h00000000);
    check({29'h00000000, rd[2:0]}, 32'h00000000);
    apb(1'b0, 8'h10, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    $display("t_reset done");
  endtask

  // Self mode: protected execute without the unlock key is ignored
  task automatic t_self;
    regw(`REG_CMD, {1'b0, `CMD_ER_EE_BUF});
    regw(`REG_CONTROL_A, 8'h01);
    check({31'h00000000, busy}, 32'h00000000);
    regw(`REG_DATA_BYTE, 8'h6C);
    link({9'h100, `REG_DATA_BYTE}, 8'h00, 1'b0);
    check(rd, 32'h0000006C);
    $display("t_self done");
  endtask

  task automatic t_enable;
    regw(`REG_DBG_RESET, `DBG_RESET_KEY);
    regw(`REG_NVM_KEY, `NVM_KEY_BYTE);
    link({9'h100, `REG_STATUS}, 8'h00, 1'b0);
    check({31'h00000000, rd[`STATUS_ACCESS]}, 32'h00000001);
    $display("t_enable done");
  endtask

  // Tagged bytes only are programmed; no read without the read command
  task automatic t_write;
    regw(`REG_CMD, {1'b0, `CMD_LD_EE_BUF});
    eew(7'h21, 8'h5A);
    eew(7'h23, 8'h3C);
    cmd(`CMD_WR_EE_PG, 1'b0, 13'h0C20, 1'b1);
    regw(`REG_CMD, {1'b0, `CMD_RD_EE});
    eer(7'h21, 8'h5A);
    eer(7'h22, 8'hFF);
    eer(7'h23, 8'h3C);
    regw(`REG_CMD, {1'b0, `CMD_NOP});
    eer(7'h21, 8'hFF);
    $display("t_write done");
  endtask

  // Page erase clears only the tagged byte of the page
  task automatic t_erase;
    regw(`REG_CMD, {1'b0, `CMD_LD_EE_BUF});
    eew(7'h21, 8'h00);
    regw(`REG_CMD, {1'b0, `CMD_ER_EE_PG});
    eew(7'h20, 8'h00);
    regw(`REG_CMD, {1'b0, `CMD_RD_EE});
    eer(7'h21, 8'hFF);
    eer(7'h23, 8'h3C);
    $display("t_erase done");
  endtask

  task automatic t_whole;
    regw(`REG_CMD, {1'b0, `CMD_LD_EE_BUF});
    eew(7'h23, 8'h00);
    cmd(`CMD_ER_EE, 1'b1, 13'h0000, 1'b1);
    regw(`REG_CMD, {1'b0, `CMD_RD_EE});
    eer(7'h23, 8'hFF);
    $display("t_whole done");
  endtask

  // Buffer cleared first, so only the new byte is tagged; the read is
  // issued inside the long erase-write run and must wait for its end
  task automatic t_ew;
    cmd(`CMD_ER_EE_BUF, 1'b1, 13'h0000, 1'b1);
    regw(`REG_CMD, {1'b0, `CMD_LD_EE_BUF});
    eew(7'h23, 8'h11);
    regw(`REG_CMD, {1'b0, `CMD_EW_EE_PG});
    link(13'h0C20, 8'h00, 1'b1);
    check({31'h00000000, busy}, 32'h00000001);
    regw(`REG_CMD, {1'b0, `CMD_RD_NVM});
    eer(7'h23, 8'h11);
    eer(7'h21, 8'hFF);
    $display("t_ew done");
  endtask

  // Table entries: execute flag, busy expected, command code
  task automatic t_codes;
    logic [8:0] tbl [19] = '{9'h0AB, 9'h0AE, 9'h0AF, 9'h0A0, 9'h0A2, 9'h0A4, 9'h0A5, 9'h0E8,
      9'h0AA, 9'h0AC, 9'h0AD, 9'h098, 9'h09A, 9'h1A6, 9'h1B8, 9'h1B9, 9'h1F8, 9'h023, 9'h100};
    foreach (tbl[k])
      cmd(tbl[k][6:0], tbl[k][8], 13'h0000, tbl[k][7]);
    $display("t_codes done");
  endtask

  // Both locks: page write refused; chip erase keeps EEPROM with the fuse set
  task automatic t_locks;
    @(posedge clock);
    readLock <= 1'b1;
    writeLock <= 1'b1;
    cmd(`CMD_WR_EE_PG, 1'b0, 13'h0C20, 1'b0);
    cmd(`CMD_ER_EE, 1'b1, 13'h0000, 1'b0);
    cmd(`CMD_CHIP_ERASE, 1'b1, 13'h0000, 1'b1);
    @(posedge clock);
    readLock <= 1'b0;
    writeLock <= 1'b0;
    regw(`REG_CMD, {1'b0, `CMD_RD_EE});
    eer(7'h23, 8'h11);
    // Without the preserve fuse the chip erase clears the EEPROM
    @(posedge clock);
    eepromPreserveFuse <= 1'b0;
    cmd(`CMD_CHIP_ERASE, 1'b1, 13'h0000, 1'b1);
    regw(`REG_CMD, {1'b0, `CMD_RD_EE});
    eer(7'h23, 8'hFF);
    $display("t_locks done");
  endtask

  initial begin
    sys_rst = 1'b1;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    readLock = 1'b0;
    writeLock = 1'b0;
    eepromPreserveFuse = 1'b1;
    errorCnt = 0;
    checks = 0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_self();
    t_enable();
    t_write();
    t_erase();
    t_whole();
    t_ew();
    t_codes();
    t_locks();
    completeRun();
  end
endmodule

`default_nettype wire
